// >>> shared/bias_pkg.sv
// Package: constants shared by the bias power-mode device and its host.
// Assumes a single 25 MHz clock domain on both ends.
package bias_pkg;

  // ****************************************
  // Power-state field encodings
  // ****************************************
  localparam logic [1:0] PWR_ACTIVE   = 2'h0;
  localparam logic [1:0] PWR_STARTUP  = 2'h1;
  localparam logic [1:0] PWR_LOWPOWER = 2'h2;
  localparam logic [1:0] PWR_SHUTDOWN = 2'h3;

  // ****************************************
  // Device register addresses
  // ****************************************
  localparam logic [3:0] REG_BOOST_LEVEL   = 4'h0;
  localparam logic [3:0] REG_POWER_STATE   = 4'h1;
  localparam logic [3:0] REG_OUTPUT_ENABLE = 4'h2;
  localparam logic [3:0] REG_OUT_CODE_A    = 4'h3;
  localparam logic [3:0] REG_OUT_CODE_B    = 4'h4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] BOOST_LEVEL_RST   = 4'hb;
  localparam logic [5:0] OUTPUT_ENABLE_RST = 6'h00;
  localparam logic [7:0] OUT_CODE_RST      = 8'h00;

  // ****************************************
  // Analog scaling (millivolts)
  // ****************************************
  localparam int BOOST_BASE_MV  = 13000;
  localparam int BOOST_STEP_MV  = 1000;
  localparam int OUT_STEP_MV    = 188;
  localparam int OUT_STEPS      = 128;
  localparam int HEADROOM_MV    = 2000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ          = 25000000;
  localparam int STARTUP_MAX_US  = 300;
  localparam int STARTUP_TYP_US  = 180;
  localparam int STARTUP_CYCLES  = STARTUP_TYP_US * (CLK_HZ / 1000000);
  localparam int STARTUP_MAX_CYC = STARTUP_MAX_US * (CLK_HZ / 1000000);

  // ****************************************
  // Host command port addresses
  // ****************************************
  localparam logic [3:0] HREG_CMD    = 4'h0;
  localparam logic [3:0] HREG_STATUS = 4'h1;
  localparam logic [3:0] HREG_RDATA  = 4'h2;

endpackage

// >>> shared/bias_if.sv
// Interface: control bus between the host and the bias device.
// Assumes one clock; writes and reads are single-cycle strobes.
`timescale 1ns/1ps
interface bias_if;
  logic       wr;
  logic       rd;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;

  modport dev  (input wr, rd, addr, wdata, output rdata, rvalid);
  modport host (output wr, rd, addr, wdata, input rdata, rvalid);
endinterface

// >>> verilog/bias_device.sv
// Device end: power-mode sequencer and default registers for two outputs.
// Assumes io_supply is asynchronous, rst is the analog-supply reset.
`timescale 1ns/1ps
module bias_device
  import bias_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  bias_if.dev              bus,
  input  wire logic        io_supply,
  output      logic [1:0]  power_state,
  output      logic        boost_enable,
  output      logic [14:0] boost_target_mv,
  output      logic [1:0]  out_drive_en,
  output      logic [1:0]  out_pull_down,
  output      logic [14:0] out_a_mv,
  output      logic [14:0] out_b_mv
);

  typedef enum logic [1:0] {
    ST_ACTIVE   = 2'b00,
    ST_STARTUP  = 2'b01,
    ST_LOWPOWER = 2'b10,
    ST_SHUTDOWN = 2'b11
  } mode_e;

  // ****************************************
  // Io supply synchroniser and edge
  // ****************************************
  logic io_meta_q, io_sync_q, io_prev_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      io_meta_q <= 1'b0;
      io_sync_q <= 1'b0;
      io_prev_q <= 1'b0;
    end else begin
      io_meta_q <= io_supply;
      io_sync_q <= io_meta_q;
      io_prev_q <= io_sync_q;
    end
  end
  // A dip that never reads low cannot make a rising edge
  wire io_rise = io_sync_q & ~io_prev_q;
  wire io_low  = ~io_sync_q;

  // ****************************************
  // Mode sequencer
  // ****************************************
  mode_e       mode_q, mode_d;
  logic [12:0] cnt_q,  cnt_d;
  logic [3:0]  boost_q;
  logic [5:0]  enable_q;
  logic [7:0]  code_a_q, code_b_q;

  wire wr_pwr   = bus.wr && bus.addr == REG_POWER_STATE;
  wire cmd_start = wr_pwr && bus.wdata[1:0] == PWR_STARTUP;
  wire cmd_act   = wr_pwr && bus.wdata[1:0] == PWR_ACTIVE;
  wire cmd_low   = wr_pwr && bus.wdata[1:0] == PWR_LOWPOWER;
  wire bus_live  = mode_q != ST_SHUTDOWN;
  localparam logic [12:0] START_LAST = 13'(STARTUP_CYCLES - 1);

  always_comb begin
    mode_d = mode_q;
    cnt_d  = cnt_q;
    case (mode_q)
      ST_SHUTDOWN: begin
        cnt_d = '0;
        if (io_rise) mode_d = ST_STARTUP;
      end
      ST_STARTUP: begin
        // Commands here are ignored
        cnt_d = cnt_q + 13'h0001;
        if (cnt_q == START_LAST) mode_d = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        cnt_d = '0;
        if (cmd_start)    mode_d = ST_STARTUP;
        else if (cmd_low) mode_d = ST_LOWPOWER;
      end
      ST_LOWPOWER: begin
        cnt_d = '0;
        if (cmd_start)    mode_d = ST_STARTUP;
        else if (cmd_act) mode_d = ST_ACTIVE;
      end
      default: mode_d = ST_SHUTDOWN;
    endcase
    if (io_low) mode_d = ST_SHUTDOWN;
  end

  // Defaults are loaded on entry to startup and in every shutdown cycle
  wire load_defaults = (mode_d == ST_STARTUP && mode_q != ST_STARTUP)
                       || mode_q == ST_SHUTDOWN;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q <= ST_SHUTDOWN;
      cnt_q  <= '0;
    end else begin
      mode_q <= mode_d;
      cnt_q  <= cnt_d;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  wire wr_ok = bus.wr && bus_live && mode_q != ST_STARTUP;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boost_q  <= BOOST_LEVEL_RST;
      enable_q <= OUTPUT_ENABLE_RST;
      code_a_q <= OUT_CODE_RST;
      code_b_q <= OUT_CODE_RST;
    end else if (load_defaults) begin
      boost_q  <= BOOST_LEVEL_RST;
      enable_q <= OUTPUT_ENABLE_RST;
      code_a_q <= OUT_CODE_RST;
      code_b_q <= OUT_CODE_RST;
    end else if (wr_ok) begin
      // Values persist in low power: only bus writes change them
      case (bus.addr)
        REG_BOOST_LEVEL:   boost_q  <= bus.wdata[3:0];
        REG_OUTPUT_ENABLE: enable_q <= bus.wdata[5:0];
        REG_OUT_CODE_A:    code_a_q <= bus.wdata;
        REG_OUT_CODE_B:    code_b_q <= bus.wdata;
        default: ;
      endcase
    end
  end

  logic [7:0] rd_mux;
  always_comb begin
    case (bus.addr)
      REG_BOOST_LEVEL:   rd_mux = {4'h0, boost_q};
      REG_POWER_STATE:   rd_mux = {6'h00, mode_q};
      REG_OUTPUT_ENABLE: rd_mux = {2'h0, enable_q};
      REG_OUT_CODE_A:    rd_mux = code_a_q;
      REG_OUT_CODE_B:    rd_mux = code_b_q;
      default:           rd_mux = 8'h00;
    endcase
  end

  // ****************************************
  // Analog controls
  // ****************************************
  wire        act   = mode_q == ST_ACTIVE;
  wire [1:0]  en_ab = enable_q[1:0] & {2{act}};
  wire [14:0] bt_mv = 15'(BOOST_BASE_MV + BOOST_STEP_MV * boost_q);
  // Code to millivolts; bit 7 of a code is left out of the scale
  function automatic logic [14:0] code_mv(input logic [7:0] code);
    return 15'(OUT_STEP_MV * code[6:0]);
  endfunction
  // Pull-down only in active mode; elsewhere the pins stay high-Z
  function automatic logic pull_on(input logic       en,
                                   input logic [7:0] code,
                                   input logic       live);
    return !en && code == 8'h00 && live;
  endfunction
  wire [14:0] a_mv  = code_mv(code_a_q);
  wire [14:0] b_mv  = code_mv(code_b_q);
  wire [1:0]  pd    = {pull_on(en_ab[1], code_b_q, act),
                       pull_on(en_ab[0], code_a_q, act)};

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus.rdata       <= 8'h00;
      bus.rvalid      <= 1'b0;
      power_state     <= PWR_SHUTDOWN;
      boost_enable    <= 1'b0;
      boost_target_mv <= '0;
      out_drive_en    <= 2'b00;
      out_pull_down   <= 2'b00;
      out_a_mv        <= '0;
      out_b_mv        <= '0;
    end else begin
      bus.rdata       <= bus.rd && bus_live ? rd_mux : 8'h00;
      bus.rvalid      <= bus.rd && bus_live;
      power_state     <= mode_q;
      boost_enable    <= mode_q == ST_STARTUP || act;
      boost_target_mv <= bt_mv;
      out_drive_en    <= en_ab;
      out_pull_down   <= pd;
      out_a_mv        <= a_mv;
      out_b_mv        <= b_mv;
    end
  end

endmodule // bias_device

// >>> verilog/bias_host.sv
// Host end: turns software register accesses into control bus cycles.
// Assumes the device answers reads one cycle after the strobe.
`timescale 1ns/1ps
module bias_host
  import bias_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  bias_if.host            bus,
  input  wire logic [3:0] sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output      logic [15:0] sw_rdata
);
  // Command word: [15] read, [11:8] device address, [7:0] data.
  // Software keeps boost 2 V above outputs; not checked here
  // A startup command in active or low power reloads the device register defaults and reruns startup
  logic [7:0] last_q;
  logic       done_q;
  wire        go = sw_wr && sw_addr == HREG_CMD;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      bus.addr  <= 4'h0;
      bus.wdata <= 8'h00;
      last_q    <= 8'h00;
      done_q    <= 1'b0;
      sw_rdata  <= 16'h0000;
    end else begin
      bus.wr    <= go && !sw_wdata[15];
      bus.rd    <= go && sw_wdata[15];
      if (go) begin
        bus.addr  <= sw_wdata[11:8];
        bus.wdata <= sw_wdata[7:0];
      end
      if (bus.rvalid) last_q <= bus.rdata;
      if (go) done_q <= 1'b0;
      else if (bus.rvalid || bus.wr) done_q <= 1'b1;
      // Read data stand only in the cycle after the read strobe
      if (sw_rd) begin
        case (sw_addr)
          HREG_STATUS: sw_rdata <= {15'h0000, done_q};
          HREG_RDATA:  sw_rdata <= {8'h00, last_q};
          default:     sw_rdata <= 16'h0000;
        endcase
      end else begin
        sw_rdata <= 16'h0000;
      end
    end
  end
endmodule // bias_host

// >>> dv/bias_props.sv
// Checker: power-mode assertions on the bias bus and status pins.
// Assumes instantiation beside the interface in the bench top.
`timescale 1ns/1ps
module bias_props
  import bias_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [3:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        rvalid,
  input wire logic        io_supply,
  input wire logic [1:0]  power_state,
  input wire logic        boost_enable,
  input wire logic [14:0] boost_target_mv,
  input wire logic [1:0]  out_drive_en,
  input wire logic [1:0]  out_pull_down,
  input wire logic [14:0] out_a_mv
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Counter, since the startup bound is far beyond a repetition
  logic [13:0] su_cnt_q;
  wire  [13:0] su_cnt_d = (power_state == PWR_STARTUP) ?
                          su_cnt_q + 14'h0001 : 14'h0000;
  wire go_act = wr && addr == REG_POWER_STATE && wdata[1:0] == PWR_ACTIVE;
  wire quiet  = out_drive_en == 2'h0 && out_pull_down == 2'h0;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) su_cnt_q <= 14'h0000;
    else su_cnt_q <= su_cnt_d;
  end
  sequence s_leave_su;
    power_state == PWR_STARTUP ##1 power_state != PWR_STARTUP;
  endsequence
  sequence s_lp_to_act;
    power_state == PWR_LOWPOWER ##1 power_state == PWR_ACTIVE;
  endsequence
  sequence s_enter_su;
    power_state == PWR_SHUTDOWN ##1 power_state == PWR_STARTUP;
  endsequence
  // Startup from shutdown needs io supply seen low, then high
  property p_su_rise;
    s_enter_su |-> !$past(io_supply, 5) && $past(io_supply, 4);
  endproperty
  property p_shut;
    power_state == PWR_SHUTDOWN |-> quiet && !boost_enable;
  endproperty
  property p_io_low;
    !io_supply [*5] |-> power_state == PWR_SHUTDOWN;
  endproperty
  property p_su_drive;
    power_state == PWR_STARTUP |-> boost_enable && quiet;
  endproperty
  property p_lp_drive;
    power_state == PWR_LOWPOWER |-> !boost_enable && quiet;
  endproperty
  property p_su_len;
    power_state == PWR_STARTUP |-> su_cnt_q < STARTUP_MAX_CYC;
  endproperty
  property p_su_exit;
    s_leave_su |-> power_state inside {PWR_ACTIVE, PWR_SHUTDOWN};
  endproperty
  property p_lp_entry;
    $changed(power_state) && power_state == PWR_LOWPOWER
      |-> $past(power_state) == PWR_ACTIVE;
  endproperty
  property p_lp_exit;
    s_lp_to_act |-> $past(go_act) || $past(go_act, 2);
  endproperty
  property p_read;
    rd && power_state != PWR_SHUTDOWN |=> rvalid;
  endproperty
  property p_pull;
    out_pull_down[0] |-> power_state == PWR_ACTIVE && !out_drive_en[0]
      && out_a_mv == 15'h0000;
  endproperty
  property p_su_dflt;
    power_state == PWR_STARTUP ##1 power_state == PWR_STARTUP
      |-> boost_target_mv == 15'h5dc0;
  endproperty
  a_shut: assert property (p_shut)
    else $error("shutdown not quiet");
  a_io_low: assert property (p_io_low)
    else $error("io low kept");
  a_su_rise: assert property (p_su_rise)
    else $error("startup without io rise");
  a_su_drive: assert property (p_su_drive)
    else $error("startup pins");
  a_lp_drive: assert property (p_lp_drive)
    else $error("lowpower pins");
  a_su_len: assert property (p_su_len)
    else $error("startup too long");
  a_su_exit: assert property (p_su_exit)
    else $error("startup exit");
  a_lp_entry: assert property (p_lp_entry)
    else $error("lp entry");
  a_lp_exit: assert property (p_lp_exit)
    else $error("lp exit");
  a_read: assert property (p_read)
    else $error("read unanswered");
  a_pull: assert property (p_pull)
    else $error("pull down");
  a_su_dflt: assert property (p_su_dflt)
    else $error("boost dflt");
endmodule // bias_props

// >>> dv/tb_tuner_bias_power_mode_control.sv
// Bench: host and device joined by the bus, driven from the sw port.
// Assumes host command word {rd, 3'b0, addr, data} and 180 us startup.
`timescale 1ns/1ps
module tb_tuner_bias_power_mode_control
  import bias_pkg::*;
;
  // ****************************************
  // Signals, instances, checking
  // ****************************************
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        io_supply = 1'b0;
  logic [3:0]  sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [15:0] sw_rdata;
  logic [1:0]  power_state;
  logic        boost_enable;
  logic [14:0] boost_target_mv;
  logic [14:0] out_a_mv;
  logic [14:0] out_b_mv;
  logic [1:0]  out_drive_en;
  logic [1:0]  out_pull_down;
  logic [15:0] exp_q[$];
  logic        rd_seen = 1'b0;
  logic [3:0]  lv;
  logic [7:0]  code;
  int          exp_mv;
  int          lim;
  int          miscompares = 0;
  int          n_compared = 0;
  bias_if bi ();
  bias_device bias_device_i (.ref_clk, .rst, .bus(bi), .io_supply,
    .power_state, .boost_enable, .boost_target_mv, .out_drive_en,
    .out_pull_down, .out_a_mv, .out_b_mv);
  bias_host bias_host_i (.ref_clk, .rst, .bus(bi), .sw_addr, .sw_wdata,
    .sw_wr, .sw_rd, .sw_rdata);
  bias_props bias_props_i (.ref_clk, .rst, .wr(bi.wr), .rd(bi.rd),
    .addr(bi.addr), .wdata(bi.wdata), .rvalid(bi.rvalid), .io_supply,
    .power_state, .boost_enable, .boost_target_mv, .out_drive_en,
    .out_pull_down, .out_a_mv);
  always #20 ref_clk = ~ref_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Read results are noted by the driver, judged here when they land
  always @(posedge ref_clk) rd_seen <= sw_rd;
  always @(negedge ref_clk) begin
    if (rd_seen && exp_q.size() > 0)
      check(sw_rdata, exp_q.pop_front(), "sw_rdata");
  end
  task automatic sw_op(input logic r, input logic [3:0] a,
                       input logic [15:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= !r;
    sw_rd <= r;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
  endtask
  task automatic dev_wr(input logic [3:0] a, input logic [7:0] d);
    sw_op(1'b0, HREG_CMD, {4'h0, a, d});
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic dev_rd(input logic [3:0] a, input logic [7:0] e);
    sw_op(1'b0, HREG_CMD, {4'h8, a, 8'h00});
    repeat (4) @(posedge ref_clk);
    exp_q.push_back({8'h00, e});
    sw_op(1'b1, HREG_RDATA, 16'h0000);
  endtask
  task automatic st(input logic [1:0] e);
    @(negedge ref_clk);
    check(16'(power_state), 16'(e), "power_state");
  endtask
  task automatic power_up();
    @(posedge ref_clk);
    io_supply <= 1'b1;
    repeat (5) @(posedge ref_clk);
    st(PWR_STARTUP);
    dev_rd(REG_BOOST_LEVEL, {4'h0, BOOST_LEVEL_RST});
    repeat (STARTUP_CYCLES) @(posedge ref_clk);
    st(PWR_ACTIVE);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin : main
    void'($urandom(62541));
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    st(PWR_SHUTDOWN);
    power_up();
    dev_rd(REG_OUTPUT_ENABLE, {2'h0, OUTPUT_ENABLE_RST});
    lv = 4'($urandom_range(15));
    // Keep the boosted supply 2 V above the highest output
    lim = (BOOST_BASE_MV + BOOST_STEP_MV * lv - HEADROOM_MV) / OUT_STEP_MV;
    if (lim > OUT_STEPS - 1) lim = OUT_STEPS - 1;
    code = 8'($urandom_range(lim, 1));
    dev_wr(REG_BOOST_LEVEL, {4'h0, lv});
    dev_wr(REG_OUT_CODE_A, code);
    dev_wr(REG_OUT_CODE_B, 8'h00);
    dev_wr(REG_OUTPUT_ENABLE, 8'h01);
    @(negedge ref_clk);
    exp_mv = BOOST_BASE_MV + BOOST_STEP_MV * lv;
    check(16'(boost_target_mv), 16'(exp_mv), "boost_target_mv");
    exp_mv = OUT_STEP_MV * code;
    check(16'(out_a_mv), 16'(exp_mv), "out_a_mv");
    check(16'(out_drive_en), 16'h0001, "out_drive_en");
    check(16'(out_pull_down), 16'h0002, "out_pull_down");
    dev_wr(REG_OUT_CODE_B, code);
    @(negedge ref_clk);
    check(16'(out_b_mv), 16'(exp_mv), "out_b_mv");
    check(16'(out_pull_down), 16'h0000, "out_pull_down");
    check(16'(out_drive_en), 16'h0001, "out_drive_en");
    dev_wr(REG_POWER_STATE, {6'h00, PWR_LOWPOWER});
    st(PWR_LOWPOWER);
    check(16'(out_drive_en), 16'h0000, "out_drive_en");
    check(16'(out_pull_down), 16'h0000, "out_pull_down");
    exp_q.push_back(16'h0001);
    sw_op(1'b1, HREG_STATUS, 16'h0000);
    dev_wr(REG_POWER_STATE, {6'h00, PWR_LOWPOWER});
    st(PWR_LOWPOWER);
    dev_rd(REG_BOOST_LEVEL, {4'h0, lv});
    dev_wr(REG_POWER_STATE, {6'h00, PWR_ACTIVE});
    st(PWR_ACTIVE);
    check(16'(out_drive_en), 16'h0001, "out_drive_en");
    dev_rd(REG_OUT_CODE_A, code);
    dev_wr(REG_POWER_STATE, {6'h00, PWR_STARTUP});
    st(PWR_STARTUP);
    dev_wr(REG_POWER_STATE, {6'h00, PWR_LOWPOWER});
    st(PWR_STARTUP);
    repeat (STARTUP_CYCLES) @(posedge ref_clk);
    st(PWR_ACTIVE);
    check(16'(out_pull_down), 16'h0003, "out_pull_down");
    dev_rd(REG_OUT_CODE_A, OUT_CODE_RST);
    dev_wr(REG_BOOST_LEVEL, 8'h03);
    io_supply <= 1'b0;
    repeat (8) @(posedge ref_clk);
    st(PWR_SHUTDOWN);
    power_up();
    dev_rd(4'hf, 8'h00);
    close_out();
  end
  initial begin : watchdog
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    close_out();
  end
endmodule // tb_tuner_bias_power_mode_control
